/* File: bench/aux_pin_load.sv */
`timescale 1ns/1ns
module aux_pin_load (
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   output logic [1:0] pin_in
);
   // Released pins sit at the pull-down level
   assign pin_in = pin_out & ~pin_oe_n;
endmodule : aux_pin_load

/* File: bench/aux_pwm_checker_asserts.sv */
`timescale 1ns/1ns
module aux_pwm_checker
   import aux_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] pin_in,
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = psel && !penable;
   wire wdone = psel && penable && pready && pwrite;
   ready_after_setup_a: assert property (setup |=> pready)
      else $error("no pready");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("long pready");
   ready_cause_a: assert property (pready |-> $past(setup))
      else $error("stray pready");
   bad_addr_a: assert property (setup && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   good_addr_a: assert property (setup && paddr < 8'h28 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped refused");
   value_width_a: assert property (
      setup && !pwrite && paddr < 8'h10 |=> prdata[31:8] == 24'h0)
      else $error("value over 8 bits");
   timer_clear_a: assert property (
      wdone && paddr == OFS_PERIOD_ZERO ##1 setup && !pwrite && paddr == OFS_COUNT
      |=> prdata[15:0] == 16'h0)
      else $error("timers not cleared");
   pin_drive_a: assert property (
      wdone && paddr == OFS_FUNC_SEL && pwdata[1:0] == 2'h0 |-> ##[1:3] pin_oe_n == 2'h0)
      else $error("pin not driven");
endmodule : aux_pwm_checker
bind dual_aux_pwm_timer aux_pwm_checker aux_pwm_checker_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n));

/* File: bench/test_dual_aux_pwm_timer.sv */
`timescale 1ns/1ns
module test_dual_aux_pwm_timer;
   import aux_pwm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] pin_in, pin_out, pin_oe_n;
   int fail_count = 0;
   int check_count = 0;
   dual_aux_pwm_timer dual_aux_pwm_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n));
   aux_pin_load aux_pin_load_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: %h not %h", $time, seen, want);
      end
   endtask : chk
   task give_verdict;
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic keep, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      if (!keep) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, 1'b0, r, e);
   endtask : wr
   task rise(input int ch, output int t);
      while (pin_in[ch] !== 1'b0) @(posedge pclk);
      while (pin_in[ch] !== 1'b1) @(posedge pclk);
      t = int'($time / CLK_PERIOD_NS);
   endtask : rise
   task fall(input int ch, output int t);
      while (pin_in[ch] !== 1'b0) @(posedge pclk);
      t = int'($time / CLK_PERIOD_NS);
   endtask : fall
   task meas(input int ch, input int hi, input int per);
      int a, b, c;
      rise(ch, a);
      fall(ch, b);
      rise(ch, c);
      chk(b - a, hi);
      chk(c - a, per);
   endtask : meas
   task t_regs;
      logic [31:0] r;
      logic e;
      logic [7:0] want [5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, 8'(4 * i), 32'h0, 1'b0, r, e);
         chk(r, {24'h0, want[i]});
      end
      xfer(1'b0, 8'h40, 32'h0, 1'b0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      xfer(1'b1, OFS_PERIOD_ZERO, 32'h20, 1'b1, r, e);
      xfer(1'b0, OFS_COUNT, 32'h0, 1'b0, r, e);
      chk({16'h0, r[15:0]}, 32'h0);
   endtask : t_regs
   task t_indep;
      int a, b;
      wr(OFS_FUNC_SEL, 32'h0);
      wr(OFS_MODE, 32'h100);
      wr(OFS_ONTIME_ZERO, 32'h2);
      wr(OFS_ONTIME_ONE, 32'h1);
      wr(OFS_PERIOD_ZERO, 32'h3);
      wr(OFS_PERIOD_ONE, 32'hFF);
      meas(0, 2 * 2, 2 * (3 + 1));
      meas(1, 2 * 1, 2 * (255 + 1));
      rise(0, a);
      wr(OFS_ONTIME_ZERO, 32'h1);
      fall(0, b);
      chk(b - a, 2 * 2);
      meas(0, 2 * 1, 2 * (3 + 1));
      wr(OFS_ONTIME_ZERO, 32'h9);
      repeat (10) @(posedge pclk);
      b = 0;
      for (int i = 0; i < 24; i++) begin
         @(posedge pclk);
         if (pin_in[0] !== 1'b1) b++;
      end
      chk(b, 0);
   endtask : t_indep
   task t_offset;
      int a, b;
      wr(OFS_MODE, 32'h0);
      wr(OFS_ONTIME_ZERO, 32'h3);
      wr(OFS_ONTIME_ONE, 32'h2);
      wr(OFS_PERIOD_ZERO, 32'h7);
      wr(OFS_PERIOD_ONE, 32'h2);
      rise(0, a);
      rise(1, b);
      chk(b - a, 2 * (2 + 1));
      meas(1, 2 * 2, 2 * (7 + 1));
   endtask : t_offset
   task t_gpio;
      logic [31:0] r;
      logic e;
      wr(OFS_FUNC_SEL, 32'h1);
      wr(OFS_GPIO_DIR, 32'h1);
      wr(OFS_GPIO_DATA, 32'h1);
      @(posedge pclk);
      chk({31'h0, pin_oe_n[0]}, 32'h0);
      xfer(1'b0, OFS_GPIO_DATA, 32'h0, 1'b0, r, e);
      chk({31'h0, r[0]}, 32'h1);
      wr(OFS_GPIO_DIR, 32'h0);
      @(posedge pclk);
      chk({31'h0, pin_oe_n[0]}, 32'h1);
      xfer(1'b0, OFS_GPIO_DATA, 32'h0, 1'b0, r, e);
      chk({31'h0, r[0]}, 32'h0);
      xfer(1'b0, OFS_STATUS, 32'h0, 1'b0, r, e);
      chk({31'h0, r[STATUS_RUN_POS]}, 32'h1);
      chk({31'h0, r[STATUS_MODE_POS]}, 32'h0);
      // Reset again in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({30'h0, pin_oe_n}, 32'h3);
      xfer(1'b0, OFS_PERIOD_ONE, 32'h0, 1'b0, r, e);
      chk(r, 32'hFF);
      xfer(1'b0, OFS_MODE, 32'h0, 1'b0, r, e);
      chk(r, 32'h0);
   endtask : t_gpio
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_indep();
      t_offset();
      t_gpio();
      give_verdict();
   end
   initial begin
      #400000;
      fail_count++;
      give_verdict();
   end
endmodule : test_dual_aux_pwm_timer

/* File: design/aux_pwm_channel.sv */
`timescale 1ns/1ns
module aux_pwm_channel
   import aux_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic step,
   input wire logic restart,
   input wire logic halt,
   input wire logic [aux_pwm_pkg::VAL_W-1:0] period,
   input wire logic [aux_pwm_pkg::VAL_W-1:0] ontime,
   output logic level,
   output logic running,
   output logic [aux_pwm_pkg::VAL_W-1:0] count
);
   typedef struct packed {
      logic [VAL_W-1:0] cnt;
      logic [VAL_W-1:0] on_time;
      logic run;
   } chan_s;

   chan_s q;
   chan_s d;

   always_comb begin
      d = q;
      if (restart) begin
         d.cnt = '0;
         d.on_time = ontime;
         d.run = 1'b1;
      end else if (halt) begin
         d.cnt = '0;
         d.run = 1'b0;
      end else if (step && q.run) begin
         if (q.cnt == period) begin
            d.cnt = '0;
            d.on_time = ontime;
         end else begin
            d.cnt = q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.run && (q.cnt < q.on_time);
   assign running = q.run;
   assign count = q.cnt;
endmodule : aux_pwm_channel

/* File: design/aux_pwm_pkg.sv */
package aux_pwm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VAL_W = 8;
   localparam int NUM_CH = 2;

   localparam logic [ADDR_W-1:0] OFS_PERIOD_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PERIOD_ONE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ONTIME_ZERO = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ONTIME_ONE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FUNC_SEL = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_GPIO_DATA = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h24;

   localparam int MODE_INDEP_BIT = 8;
   localparam int STATUS_LEVEL_POS = 0;
   localparam int STATUS_RUN_POS = 2;
   localparam int STATUS_MODE_POS = 4;
   localparam int COUNT_ONE_POS = 8;

   localparam logic [VAL_W-1:0] PERIOD_RESET = 8'hFF;
   localparam logic [VAL_W-1:0] ONTIME_RESET = 8'h00;
   localparam logic MODE_RESET = 1'b0;
   localparam logic [NUM_CH-1:0] FUNC_SEL_RESET = 2'h3;
   localparam logic [NUM_CH-1:0] GPIO_DIR_RESET = 2'h0;
   localparam logic [NUM_CH-1:0] GPIO_DATA_RESET = 2'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0;

   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_CLOCKS = 2;
endpackage : aux_pwm_pkg

/* File: design/dual_aux_pwm_timer.sv */
// How it works
// - Two 8-bit pulse-width outputs on pins
// - Mode bit 8 set selects independent mode
// - Independent mode: each period register sets its output's period
// - Period is two times value-plus-one
// - Any period value 0 to 0xFF accepted
// - High time is two times on-time value
// - On-time beyond period holds output high
// - Bit 8 clear: shared period from register zero
// - Offset mode keeps per-output on-time
// - Output one rises two times offset-plus-one later
// - New on-time applies at next cycle
// - Period write clears timers, restarts cycles
// - Reset clears mode bit: offset mode
// - Reset: periods all ones, on-times zero
// - Function-select set gives pin to GPIO
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module dual_aux_pwm_timer
   import aux_pwm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [aux_pwm_pkg::ADDR_W-1:0] paddr,
   input wire logic [aux_pwm_pkg::DATA_W-1:0] pwdata,
   output logic [aux_pwm_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [aux_pwm_pkg::NUM_CH-1:0] pin_in,
   output logic [aux_pwm_pkg::NUM_CH-1:0] pin_out,
   output logic [aux_pwm_pkg::NUM_CH-1:0] pin_oe_n
);
   import aux_pwm_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0][VAL_W-1:0] period;
      logic [NUM_CH-1:0][VAL_W-1:0] ontime;
      logic mode_indep;
      logic [NUM_CH-1:0] func_sel;
      logic [NUM_CH-1:0] gpio_dir;
      logic [NUM_CH-1:0] gpio_data;
      logic phase;
      logic started;
      logic [DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
      logic [NUM_CH-1:0] pin_out;
      logic [NUM_CH-1:0] pin_oe_n;
   } top_s;

   localparam top_s RESET_STATE = '{
      period: {PERIOD_RESET, PERIOD_RESET},
      ontime: {ONTIME_RESET, ONTIME_RESET},
      mode_indep: MODE_RESET,
      func_sel: FUNC_SEL_RESET,
      gpio_dir: GPIO_DIR_RESET,
      gpio_data: GPIO_DATA_RESET,
      phase: 1'b0,
      started: 1'b0,
      rdata: READ_ZERO,
      ready: 1'b0,
      slverr: 1'b0,
      pin_out: '0,
      pin_oe_n: '1
   };

   top_s q;
   top_s d;

   logic [NUM_CH-1:0] ch_restart;
   logic [NUM_CH-1:0] ch_halt;
   logic [NUM_CH-1:0][VAL_W-1:0] ch_period;
   logic [NUM_CH-1:0] ch_level;
   logic [NUM_CH-1:0] ch_running;
   logic [NUM_CH-1:0][VAL_W-1:0] ch_count;

   logic access_wr;
   logic setup;
   logic period_write;
   logic step;
   logic [VAL_W:0] offset_raw;
   logic [VAL_W:0] period_len;
   logic [VAL_W:0] offset_pos;
   logic [VAL_W-1:0] next_zero;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] count_word;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
         aux_pwm_channel u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .step(step),
            .restart(ch_restart[gi]),
            .halt(ch_halt[gi]),
            .period(ch_period[gi]),
            .ontime(q.ontime[gi]),
            .level(ch_level[gi]),
            .running(ch_running[gi]),
            .count(ch_count[gi])
         );
      end
   endgenerate

   // periods per output in independent mode
   always_comb begin
      ch_period[0] = q.period[0];
      if (q.mode_indep) begin
         ch_period[1] = q.period[1];
      end else begin
         ch_period[1] = q.period[0];
      end
   end

   always_comb begin
      offset_raw = {1'b0, q.period[1]} + 9'h001;
      period_len = {1'b0, q.period[0]} + 9'h001;
      if (offset_raw >= period_len) begin
         offset_pos = offset_raw - period_len;
      end else begin
         offset_pos = offset_raw;
      end
      if (ch_count[0] == q.period[0]) begin
         next_zero = '0;
      end else begin
         next_zero = ch_count[0] + 8'h01;
      end
   end

   always_comb begin
      status_word = READ_ZERO;
      status_word[STATUS_LEVEL_POS +: NUM_CH] = ch_level;
      status_word[STATUS_RUN_POS +: NUM_CH] = ch_running;
      status_word[STATUS_MODE_POS] = q.mode_indep;
      count_word = READ_ZERO;
      count_word[VAL_W-1:0] = ch_count[0];
      count_word[COUNT_ONE_POS +: VAL_W] = ch_count[1];
   end

   assign setup = psel && !penable;
   assign access_wr = psel && penable && q.ready && pwrite && !q.slverr;
   assign period_write = access_wr &&
      ((paddr == OFS_PERIOD_ZERO) || (paddr == OFS_PERIOD_ONE));
   assign step = q.phase;

   always_comb begin
      d = q;
      ch_restart = '0;
      ch_halt = '0;
      d.phase = ~q.phase;

      // Register writes at the access edge
      if (access_wr) begin
         unique case (paddr)
            OFS_PERIOD_ZERO: d.period[0] = pwdata[VAL_W-1:0];
            OFS_PERIOD_ONE: d.period[1] = pwdata[VAL_W-1:0];
            OFS_ONTIME_ZERO: d.ontime[0] = pwdata[VAL_W-1:0];
            OFS_ONTIME_ONE: d.ontime[1] = pwdata[VAL_W-1:0];
            OFS_MODE: d.mode_indep = pwdata[MODE_INDEP_BIT];
            OFS_FUNC_SEL: d.func_sel = pwdata[NUM_CH-1:0];
            OFS_GPIO_DIR: d.gpio_dir = pwdata[NUM_CH-1:0];
            OFS_GPIO_DATA: d.gpio_data = pwdata[NUM_CH-1:0];
            default: d.func_sel = q.func_sel;
         endcase
      end

      if (period_write || !q.started) begin
         d.started = 1'b1;
         d.phase = 1'b0;
         ch_restart[0] = 1'b1;
         if (q.mode_indep || (offset_pos == 9'h000)) begin
            ch_restart[1] = 1'b1;
         end else begin
            ch_halt[1] = 1'b1;
         end
      end else if (step && !q.mode_indep && ch_running[0]) begin
         if ({1'b0, next_zero} == offset_pos) begin
            ch_restart[1] = 1'b1;
         end
      end

      // APB answer prepared in setup, shown in access
      d.ready = 1'b0;
      d.slverr = 1'b0;
      if (setup) begin
         d.ready = 1'b1;
         d.rdata = READ_ZERO;
         unique case (paddr)
            OFS_PERIOD_ZERO: d.rdata[VAL_W-1:0] = q.period[0];
            OFS_PERIOD_ONE: d.rdata[VAL_W-1:0] = q.period[1];
            OFS_ONTIME_ZERO: d.rdata[VAL_W-1:0] = q.ontime[0];
            OFS_ONTIME_ONE: d.rdata[VAL_W-1:0] = q.ontime[1];
            OFS_MODE: d.rdata[MODE_INDEP_BIT] = q.mode_indep;
            OFS_FUNC_SEL: d.rdata[NUM_CH-1:0] = q.func_sel;
            OFS_GPIO_DIR: d.rdata[NUM_CH-1:0] = q.gpio_dir;
            OFS_GPIO_DATA: d.rdata[NUM_CH-1:0] = pin_in;
            OFS_STATUS: d.rdata = status_word;
            OFS_COUNT: d.rdata = count_word;
            default: d.slverr = 1'b1;
         endcase
      end

      // function select picks GPIO or pulse
      for (int i = 0; i < NUM_CH; i++) begin
         if (q.func_sel[i]) begin
            d.pin_out[i] = q.gpio_data[i];
            d.pin_oe_n[i] = ~q.gpio_dir[i];
         end else begin
            d.pin_out[i] = ch_level[i];
            d.pin_oe_n[i] = 1'b0;
         end
      end
   end

   // reset values of period and on-time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.slverr;
   assign pin_out = q.pin_out;
   assign pin_oe_n = q.pin_oe_n;
endmodule : dual_aux_pwm_timer
